// ==== verilog/sfr_read_engine.sv ====
// Read-command engine of a serial flash slave, sampled on the reference clock
`timescale 1ns/1ps

// Summary of operation
// RL1 - Host sends read opcode, then 24-bit address
// RL2 - Opcode and address captured on rising clock
// RL3 - Data shifted out MSB first on falling edges
// RL4 - Read address advances after every byte
// RL5 - Select high ends the read
// RL6 - Reads while busy are discarded
// RL7 - Fast read waits eight dummy clocks
// RL8 - Dual output returns two bits per clock
// RL9 - Host releases line zero before data
// RL10 - Quad output returns four bits per clock
// RL11 - Quad output needs quad enable set
// RL12 - Host releases all lines before data
// RL13 - Dual I/O takes address two bits per clock
// RL14 - Mode byte follows address in I/O reads
// RL15 - Nibble A skips opcode on next dual read
// RL16 - Other nibble restores normal opcode decoding
// RL17 - Mode-bit reset command clears opcode skipping; when armed it is not decoded, only a mode nibble other than A clears it
// RL18 - Host issues high-performance command beforehand
// RL19 - Quad I/O: four-bit address, four dummy clocks
// RL20 - Quad I/O needs quad enable set
// RL21 - Nibble A skips opcode on next quad read
// RL22 - Dual data: line one odd, zero even
// RL23 - Dual address: line one carries bit 23
// RL24 - Quad address: line three holds highest bit
// RL25 - Quad data: upper nibble first, bit seven high
// RL26 - Drivers enabled only in data, used lines
module sfr_read_engine (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_sel_n,
   input wire logic i_sclk,
   input wire logic i_data_line_zero,
   input wire logic i_data_line_one,
   input wire logic i_data_line_two,
   input wire logic i_data_line_three,
   input wire logic i_busy,
   input wire logic i_quad_enable_bit,
   input wire logic [sfr_pkg::DATA_W-1:0] i_mem_data,
   output logic o_data_line_zero,
   output logic o_data_line_one,
   output logic o_data_line_two,
   output logic o_data_line_three,
   output logic o_data_line_zero_oe,
   output logic o_data_line_one_oe,
   output logic o_data_line_two_oe,
   output logic o_data_line_three_oe,
   output logic [sfr_pkg::ADDR_W-1:0] o_mem_addr,
   output logic o_read_active,
   output logic o_cont_read_armed
);
   import sfr_pkg::*;

   // Synchroniser stages for the pins
   logic sclk_s1, sclk_s2, sclk_d;
   logic sel_s1, sel_s2;
   logic [3:0] io_s1, io_s2;
   // Sequencer state
   sfr_state_t state;
   logic [4:0] bit_cnt; // Bits taken in current phase
   logic [3:0] dummy_cnt; // Dummy clocks seen
   logic [31:0] shreg; // Opcode, address and mode accumulator
   logic [2:0] in_w; // Lines per clock for address and mode
   logic [2:0] out_w; // Lines per clock for data
   logic [3:0] dummy_len; // Dummy clocks for this command
   logic has_mode; // Mode byte follows the address
   // Continuous-read memory
   logic armed; // Next select skips the opcode
   logic cont_quad; // Armed read is quad rather than dual
   // Output shifter
   logic [ADDR_W-1:0] rd_addr;
   logic [7:0] out_byte;
   logic [3:0] out_left;
   logic [3:0] lines;
   logic [3:0] oe;
   logic data_started;

   // Right-align the bits taken in one clock at the given width
   function automatic logic [31:0] shift_in(input logic [31:0] acc, input logic [2:0] w,
                                            input logic [3:0] io);
      logic [31:0] r;
      r = {acc[27:0], io};
      if (w == W_ONE) begin
         r = {acc[30:0], io[0]};
      end else if (w == W_TWO) begin
         r = {acc[29:0], io[1:0]};
      end
      return r;
   endfunction : shift_in

   // Place the top bits of a byte onto the data lines
   function automatic logic [3:0] place_out(input logic [2:0] w, input logic [7:0] b);
      logic [3:0] r;
      r = b[7:4];
      if (w == W_ONE) begin
         r = {2'h0, b[7], 1'b0};
      end else if (w == W_TWO) begin
         r = {2'h0, b[7:6]};
      end
      return r;
   endfunction : place_out

   // Driver enables for a data width
   function automatic logic [3:0] lane_en(input logic [2:0] w);
      logic [3:0] r;
      r = 4'hF;
      if (w == W_ONE) begin
         r = 4'h2;
      end else if (w == W_TWO) begin
         r = 4'h3;
      end
      return r;
   endfunction : lane_en

   // Two-stage synchronisers plus an edge history stage for the clock
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d <= 1'b0;
         sel_s1 <= 1'b1;
         sel_s2 <= 1'b1;
         io_s1 <= 4'h0;
         io_s2 <= 4'h0;
      end else begin
         sclk_s1 <= i_sclk;
         sclk_s2 <= sclk_s1;
         sclk_d <= sclk_s2;
         sel_s1 <= i_sel_n;
         sel_s2 <= sel_s1;
         io_s1 <= {i_data_line_three, i_data_line_two, i_data_line_one, i_data_line_zero};
         io_s2 <= io_s1;
      end
   end

   // Edge and select detection
   logic rise, fall, sel_act;
   assign rise = sclk_s2 & ~sclk_d;
   assign fall = ~sclk_s2 & sclk_d;
   assign sel_act = ~sel_s2;

   // Width in use for the current input phase
   logic [2:0] cur_w;
   logic [31:0] shin;
   logic [4:0] cnt_step;
   logic [7:0] opcode_now;
   logic op_last;
   assign cur_w = (state == ST_OPCODE) ? W_ONE : in_w;
   assign shin = shift_in(shreg, cur_w, io_s2);
   assign cnt_step = bit_cnt + {2'h0, cur_w};
   assign opcode_now = shin[7:0];
   assign op_last = (state == ST_OPCODE) && rise && (cnt_step == OPCODE_BITS);

   // Opcode decode into phase widths and dummy length
   logic dec_read, dec_ok, dec_mode;
   logic [2:0] dec_in_w, dec_out_w;
   logic [3:0] dec_dummy;
   always_comb begin
      dec_read = 1'b1;
      dec_mode = 1'b0;
      dec_in_w = W_ONE;
      dec_out_w = W_ONE;
      dec_dummy = DUMMY_NONE;
      dec_ok = 1'b1;
      unique case (opcode_now)
         OP_READ: begin
            dec_dummy = DUMMY_NONE;
         end
         OP_FAST: begin
            dec_dummy = DUMMY_FAST; // [RL7]
         end
         OP_DUAL_OUT: begin
            dec_out_w = W_TWO; // [RL8]
            dec_dummy = DUMMY_FAST;
         end
         OP_QUAD_OUT: begin
            dec_out_w = W_FOUR; // [RL10]
            dec_dummy = DUMMY_FAST;
            dec_ok = i_quad_enable_bit; // [RL11]
         end
         OP_DUAL_IO: begin
            dec_in_w = W_TWO; // [RL13]
            dec_out_w = W_TWO;
            dec_mode = 1'b1; // [RL14]
         end
         OP_QUAD_IO: begin
            dec_in_w = W_FOUR; // [RL19]
            dec_out_w = W_FOUR;
            dec_mode = 1'b1;
            dec_dummy = DUMMY_QIO;
            dec_ok = i_quad_enable_bit; // [RL20]
         end
         default: begin
            // Mode reset, high-performance and others end quietly [RL18]
            dec_read = 1'b0;
            dec_ok = 1'b0;
         end
      endcase
      if (i_busy) begin
         dec_ok = 1'b0; // [RL6]
      end
   end

   // Command sequencer, advanced on rising serial clock edges
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !sel_act) begin
         state <= ST_IDLE; // [RL5]
         bit_cnt <= 5'h00;
         dummy_cnt <= 4'h0;
         shreg <= 32'h0000_0000;
         in_w <= W_ONE;
         out_w <= W_ONE;
         dummy_len <= DUMMY_NONE;
         has_mode <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               // Armed reads start straight at the address
               if (!armed) begin
                  state <= ST_OPCODE;
               end else if (i_busy) begin
                  state <= ST_DISCARD; // [RL6]
               end else begin
                  state <= ST_ADDR; // [RL15] [RL21]
                  in_w <= cont_quad ? W_FOUR : W_TWO;
                  out_w <= cont_quad ? W_FOUR : W_TWO;
                  dummy_len <= cont_quad ? DUMMY_QIO : DUMMY_NONE;
                  has_mode <= 1'b1;
               end
            end
            ST_OPCODE: begin
               if (rise) begin
                  shreg <= shin; // [RL1] [RL2]
                  bit_cnt <= cnt_step;
                  if (op_last) begin
                     bit_cnt <= 5'h00;
                     state <= dec_ok ? ST_ADDR : ST_DISCARD;
                     in_w <= dec_in_w;
                     out_w <= dec_out_w;
                     dummy_len <= dec_dummy;
                     has_mode <= dec_mode;
                  end
               end
            end
            ST_ADDR: begin
               if (rise) begin
                  shreg <= shin; // [RL2] [RL23] [RL24]
                  bit_cnt <= cnt_step;
                  if (cnt_step == ADDR_BITS) begin
                     bit_cnt <= 5'h00;
                     if (has_mode) begin
                        state <= ST_MODE;
                     end else begin
                        state <= (dummy_len != DUMMY_NONE) ? ST_DUMMY : ST_DATA;
                     end
                  end
               end
            end
            ST_MODE: begin
               if (rise) begin
                  shreg <= shin; // [RL14]
                  bit_cnt <= cnt_step;
                  if (cnt_step == MODE_BITS) begin
                     bit_cnt <= 5'h00;
                     state <= (dummy_len != DUMMY_NONE) ? ST_DUMMY : ST_DATA;
                  end
               end
            end
            ST_DUMMY: begin
               if (rise) begin
                  dummy_cnt <= dummy_cnt + 4'h1; // [RL7] [RL19]
                  if (dummy_cnt + 4'h1 == dummy_len) begin
                     state <= ST_DATA;
                  end
               end
            end
            ST_DATA, ST_DISCARD: begin
               state <= state; // Held until select rises
            end
         endcase
      end
   end

   // Continuous-read arm: set by mode nibble A, cleared by any other mode nibble
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         armed <= 1'b0;
         cont_quad <= 1'b0;
      end else if (sel_act && state == ST_MODE && rise && cnt_step == MODE_BITS) begin
         armed <= (shin[7:4] == CONT_NIBBLE); // [RL15] [RL16] [RL21]
         cont_quad <= (in_w == W_FOUR);
      end else if (sel_act && op_last && opcode_now == OP_MODE_RST) begin
         armed <= 1'b0; // [RL17]
      end
   end

   // Start address sits above the mode byte when one was taken
   logic [ADDR_W-1:0] start_addr;
   assign start_addr = has_mode ? shreg[31:8] : shreg[23:0];

   // Output shifter, changing lines on falling serial clock edges
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !sel_act || state != ST_DATA) begin
         oe <= 4'h0; // [RL26] [RL5]
         out_left <= 4'h0;
         data_started <= 1'b0;
         rd_addr <= start_addr;
      end else if (fall) begin
         data_started <= 1'b1;
         // Drivers come on at the first data fall, after host release [RL9] [RL12]
         oe <= lane_en(out_w); // [RL26]
         if (out_left == 4'h0) begin
            lines <= place_out(out_w, i_mem_data); // [RL3] [RL22] [RL25]
            out_byte <= i_mem_data << out_w;
            out_left <= BYTE_BITS - {1'b0, out_w};
            rd_addr <= rd_addr + 24'h00_0001; // [RL4]
         end else begin
            lines <= place_out(out_w, out_byte); // [RL3]
            out_byte <= out_byte << out_w;
            out_left <= out_left - {1'b0, out_w};
         end
      end else if (!data_started) begin
         rd_addr <= start_addr;
      end
   end

   // Output wiring from flops
   assign o_data_line_zero = lines[0];
   assign o_data_line_one = lines[1];
   assign o_data_line_two = lines[2];
   assign o_data_line_three = lines[3];
   assign o_data_line_zero_oe = oe[0];
   assign o_data_line_one_oe = oe[1];
   assign o_data_line_two_oe = oe[2];
   assign o_data_line_three_oe = oe[3];
   assign o_mem_addr = rd_addr;
   assign o_read_active = (state == ST_DATA);
   assign o_cont_read_armed = armed;

   // Checks on the sequencer and shifter
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);

   sequence s_mode_done;
      sel_act && state == ST_MODE && rise && cnt_step == MODE_BITS;
   endsequence
   sequence s_op_done;
      sel_act && op_last;
   endsequence

   property p_sel_ends;
      !sel_act |=> (state == ST_IDLE && oe == 4'h0);
   endproperty
   a_sel_ends: assert property (p_sel_ends) else $error("select high did not end read"); // [RL5] [RL26]

   property p_busy_drop;
      s_op_done ##0 (i_busy && dec_read) |=> state == ST_DISCARD;
   endproperty
   a_busy_drop: assert property (p_busy_drop) else $error("read taken while busy"); // [RL6]

   property p_qe_gate;
      s_op_done ##0 (!i_quad_enable_bit && (opcode_now == OP_QUAD_OUT || opcode_now == OP_QUAD_IO))
         |=> state == ST_DISCARD;
   endproperty
   a_qe_gate: assert property (p_qe_gate) else $error("quad read taken without quad enable"); // [RL11] [RL20]

   property p_fast_dummy;
      s_op_done ##0 (opcode_now == OP_FAST && !i_busy) |=> (state == ST_ADDR && dummy_len == DUMMY_FAST);
   endproperty
   a_fast_dummy: assert property (p_fast_dummy) else $error("fast read dummy length wrong"); // [RL7]

   property p_addr_step;
      (sel_act && state == ST_ADDR && rise && cnt_step != ADDR_BITS) |=> bit_cnt == $past(cnt_step);
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address bits not counted by width"); // [RL2]

   property p_addr_inc;
      (sel_act && state == ST_DATA && fall && out_left == 4'h0) |=> rd_addr == $past(rd_addr) + 24'h00_0001;
   endproperty
   a_addr_inc: assert property (p_addr_inc) else $error("read address did not advance"); // [RL4]

   property p_arm;
      s_mode_done ##0 (shin[7:4] == CONT_NIBBLE) |=> armed;
   endproperty
   a_arm: assert property (p_arm) else $error("mode nibble A did not arm"); // [RL15]

   property p_disarm;
      s_mode_done ##0 (shin[7:4] != CONT_NIBBLE) |=> !armed;
   endproperty
   a_disarm: assert property (p_disarm) else $error("other mode nibble left armed"); // [RL16]

   property p_skip;
      (sel_act && state == ST_IDLE && armed && !i_busy) |=> state == ST_ADDR;
   endproperty
   a_skip: assert property (p_skip) else $error("armed read expected opcode"); // [RL21]

   property p_mode_rst;
      s_op_done ##0 (opcode_now == OP_MODE_RST) |=> !armed;
   endproperty
   a_mode_rst: assert property (p_mode_rst) else $error("mode reset left armed"); // [RL17]

   property p_fall_only;
      $changed(lines) |-> $past(fall);
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("data changed off a falling edge"); // [RL3]

   property p_dual_lanes;
      (state == ST_DATA && out_w == W_TWO) |-> oe[3:2] == 2'h0;
   endproperty
   a_dual_lanes: assert property (p_dual_lanes) else $error("dual read drove upper lines"); // [RL8] [RL26]
endmodule : sfr_read_engine

// ==== shared/sfr_pkg.sv ====
// Constants and types shared by the serial flash read engine
package sfr_pkg;
   // Read opcodes taken on the serial input line
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
   localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
   localparam logic [7:0] OP_DUAL_IO = 8'hBB;
   localparam logic [7:0] OP_QUAD_IO = 8'hEB;
   // High-performance-mode command, accepted as a no-op here
   localparam logic [7:0] OP_HIGH_PERF = 8'hA3;
   // Mode-bit reset command
   localparam logic [7:0] OP_MODE_RST = 8'hFF;
   // Address and data widths
   localparam int ADDR_W = 24;
   localparam int DATA_W = 8;
   // Phase lengths in bits
   localparam logic [4:0] OPCODE_BITS = 5'h08;
   localparam logic [4:0] ADDR_BITS = 5'h18;
   localparam logic [4:0] MODE_BITS = 5'h08;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Dummy clock counts
   localparam logic [3:0] DUMMY_NONE = 4'h0;
   localparam logic [3:0] DUMMY_FAST = 4'h8;
   localparam logic [3:0] DUMMY_QIO = 4'h4;
   // Mode upper nibble that arms opcode-less reads
   localparam logic [3:0] CONT_NIBBLE = 4'hA;
   // Lines per clock
   localparam logic [2:0] W_ONE = 3'h1;
   localparam logic [2:0] W_TWO = 3'h2;
   localparam logic [2:0] W_FOUR = 3'h4;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPCODE,
      ST_ADDR,
      ST_MODE,
      ST_DUMMY,
      ST_DATA,
      ST_DISCARD
   } sfr_state_t;
endpackage : sfr_pkg

// ==== tb/sfr_host_model.sv ====
// Behavioural SPI host that issues read frames to the flash read engine
`timescale 1ns/1ps
module sfr_host_model (
   input wire logic i_ref_clk,
   input wire logic [3:0] i_dev_val,
   input wire logic [3:0] i_dev_oe,
   output logic o_sel_n,
   output logic o_sclk,
   output logic [3:0] o_line
);
   logic [3:0] h_val = 4'h0; // Host drive values
   logic [3:0] h_oe = 4'h0; // Host drive enables
   logic float_v = 1'b0; // Pattern on undriven lines
   logic sel_q = 1'b1; // Select level, idle high
   logic sclk_q = 1'b0; // Serial clock level, parked low

   // Undriven lines toggle so stale values never look valid
   always @(posedge i_ref_clk) begin
      float_v <= ~float_v;
   end

   // Wire level from both parties' enables
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         o_line[i] = h_oe[i] ? h_val[i] : (i_dev_oe[i] ? i_dev_val[i] : float_v);
      end
   end

   // Pin levels come from one holder each
   assign o_sel_n = sel_q;
   assign o_sclk = sclk_q;

   // One serial clock of 48 ns; device output sampled just before the fall
   task clk(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] smp, output logic [3:0] soe);
      h_val = v;
      h_oe = oe;
      #24 sclk_q = 1'b1;
      #23 smp = o_line;
      soe = i_dev_oe;
      #1 sclk_q = 1'b0;
   endtask : clk

   // Select falls with the clock parked low; the quarter offset keeps every pin change off a reference edge
   task start();
      @(posedge i_ref_clk);
      #1.25 sel_q = 1'b0;
      #30;
   endtask : start

   // Release lines and raise select; clock stands still afterwards
   task stop();
      h_oe = 4'h0;
      #30 sel_q = 1'b1;
      #200;
   endtask : stop

   // One byte, MSB first, w lines per clock with the highest line first
   task send_byte(input int w, input logic [7:0] b);
      logic [7:0] s;
      logic [3:0] d;
      logic [3:0] e;
      s = b;
      repeat (8 / w) begin
         clk(s[7:4] >> (4 - w), (4'h1 << w) - 4'h1, d, e);
         s = s << w;
      end
   endtask : send_byte

   // Dummy clocks with every line released
   task dummy(input int n);
      logic [3:0] d;
      logic [3:0] e;
      repeat (n) clk(4'h0, 4'h0, d, e);
   endtask : dummy

   // Four data bytes, lines released, enables gathered
   task rd_word(input int w, output logic [31:0] v, output logic [3:0] oe);
      logic [3:0] d;
      logic [3:0] e;
      v = 32'h0;
      oe = 4'h0;
      repeat (32 / w) begin
         clk(4'h0, 4'h0, d, e);
         oe = oe | e;
         case (w)
            1: v = {v[30:0], d[1]};
            2: v = {v[29:0], d[1:0]};
            default: v = {v[27:0], d};
         endcase
      end
   endtask : rd_word
endmodule : sfr_host_model

// ==== tb/sfr_read_engine_test.sv ====
// Self-checking testbench of the serial flash read engine
`timescale 1ns/1ps
module sfr_read_engine_test;
   import sfr_pkg::*;
   logic i_ref_clk; // Reference clock
   logic i_srst; // Synchronous reset
   logic busy = 1'b0; // Program cycle in progress
   logic qe = 1'b0; // Quad enable status
   logic sel_n; // Select from host
   logic sclk; // Serial clock from host
   logic [3:0] line; // Resolved data lines
   logic [3:0] dval; // Device line values
   logic [3:0] doe; // Device line enables
   logic [DATA_W-1:0] mem_data; // Memory byte
   logic [ADDR_W-1:0] mem_addr; // Memory address
   logic rd_act; // Data phase flag
   logic armed; // Opcode skip armed
   int fail_count = 0; // Mismatches
   int total_checks = 0; // Comparisons made

   // Reference clock, 5 ns period
   initial begin
      i_ref_clk = 1'b0;
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   // Memory contents as a function of address
   function automatic logic [7:0] mem_f(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
   endfunction : mem_f

   assign mem_data = mem_f(mem_addr);

   sfr_read_engine dut (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_sel_n(sel_n),
      .i_sclk(sclk),
      .i_data_line_zero(line[0]),
      .i_data_line_one(line[1]),
      .i_data_line_two(line[2]),
      .i_data_line_three(line[3]),
      .i_busy(busy),
      .i_quad_enable_bit(qe),
      .i_mem_data(mem_data),
      .o_data_line_zero(dval[0]),
      .o_data_line_one(dval[1]),
      .o_data_line_two(dval[2]),
      .o_data_line_three(dval[3]),
      .o_data_line_zero_oe(doe[0]),
      .o_data_line_one_oe(doe[1]),
      .o_data_line_two_oe(doe[2]),
      .o_data_line_three_oe(doe[3]),
      .o_mem_addr(mem_addr),
      .o_read_active(rd_act),
      .o_cont_read_armed(armed)
   );

   sfr_host_model host (
      .i_ref_clk(i_ref_clk),
      .i_dev_val(dval),
      .i_dev_oe(doe),
      .o_sel_n(sel_n),
      .o_sclk(sclk),
      .o_line(line)
   );

   // Compare a data word
   task chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   // Compare a flag group
   task chk_flag(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_flag

   // Status inputs change just after a reference edge
   task set_st(input logic b, input logic q);
      @(posedge i_ref_clk);
      #1.25 busy = b;
      qe = q;
   endtask : set_st

   // One read frame: opcode, address, mode, dummies, four data bytes
   task do_read(input logic [7:0] op, input bit op_on, input int aw, input logic [7:0] mode,
                input int nd, input int dw, input logic [23:0] a, input bit ok, input bit arm);
      logic [31:0] v;
      logic [3:0] oe;
      logic [3:0] mask;
      logic act;
      host.start();
      if (op_on) host.send_byte(1, op);
      host.send_byte(aw, a[23:16]);
      host.send_byte(aw, a[15:8]);
      host.send_byte(aw, a[7:0]);
      if (aw > 1) host.send_byte(aw, mode);
      host.dummy(nd);
      host.rd_word(dw, v, oe);
      // Data phase flag taken while select is still low
      act = rd_act;
      host.stop();
      mask = (dw == 1) ? 4'h2 : ((dw == 2) ? 4'h3 : 4'hF);
      chk_flag({3'h0, act}, {3'h0, ok});
      chk_flag(oe, ok ? mask : 4'h0);
      if (ok) chk_word(v, {mem_f(a), mem_f(a + 24'h1), mem_f(a + 24'h2), mem_f(a + 24'h3)});
      chk_flag({3'h0, armed}, {3'h0, arm});
      chk_flag({3'h0, rd_act}, 4'h0);
      chk_flag(doe, 4'h0);
   endtask : do_read

   // Verdict and end of run
   task end_of_test();
      $display("checks=%0d failures=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   // Hang guard
   initial begin
      #300000;
      fail_count++;
      end_of_test();
   end

   // Main sequence
   initial begin
      i_srst = 1'b1;
      repeat (6) @(posedge i_ref_clk);
      #1.25 i_srst = 1'b0;
      repeat (4) @(posedge i_ref_clk);
      // Single and dual output reads, address carry across a byte
      do_read(OP_READ, 1, 1, 8'h00, 0, 1, 24'h1234FE, 1, 0);
      do_read(OP_FAST, 1, 1, 8'h00, 8, 1, 24'h00ABCD, 1, 0);
      do_read(OP_DUAL_OUT, 1, 1, 8'h00, 8, 2, 24'h7FFF00, 1, 0);
      $display("test plain done");
      // Quad reads refused without quad enable, then accepted
      do_read(OP_QUAD_OUT, 1, 1, 8'h00, 8, 4, 24'h000010, 0, 0);
      do_read(OP_QUAD_IO, 1, 4, 8'hA0, 4, 4, 24'h000020, 0, 0);
      set_st(1'b0, 1'b1);
      do_read(OP_QUAD_OUT, 1, 1, 8'h00, 8, 4, 24'h345678, 1, 0);
      do_read(OP_QUAD_IO, 1, 4, 8'h5F, 4, 4, 24'h9ABCDE, 1, 0);
      $display("test quad done");
      // Opcode-skipping reads armed and disarmed by the mode byte
      do_read(OP_HIGH_PERF, 1, 1, 8'h00, 0, 1, 24'h000000, 0, 0);
      do_read(OP_DUAL_IO, 1, 2, 8'hA5, 0, 2, 24'h111111, 1, 1);
      do_read(8'h00, 0, 2, 8'hAF, 0, 2, 24'h222222, 1, 1);
      do_read(8'h00, 0, 2, 8'h3A, 0, 2, 24'h333333, 1, 0);
      do_read(OP_QUAD_IO, 1, 4, 8'hA0, 4, 4, 24'h444444, 1, 1);
      // Armed read while busy is dropped and keeps the opcode skip
      set_st(1'b1, 1'b1);
      do_read(8'h00, 0, 4, 8'hA0, 4, 4, 24'h454545, 0, 1);
      set_st(1'b0, 1'b1);
      do_read(8'h00, 0, 4, 8'hF0, 4, 4, 24'h555555, 1, 0);
      // Armed host clears the mode with all ones, then a plain mode reset is refused
      do_read(OP_QUAD_IO, 1, 4, 8'hAA, 4, 4, 24'h666666, 1, 1);
      host.start();
      repeat (4) host.send_byte(4, 8'hFF);
      host.stop();
      chk_flag({3'h0, armed}, 4'h0);
      do_read(OP_MODE_RST, 1, 1, 8'h00, 0, 1, 24'hFFFFFF, 0, 0);
      $display("test continuous done");
      // Reads while busy and unknown opcodes give no output, then a plain read across a carry does
      set_st(1'b1, 1'b1);
      do_read(OP_READ, 1, 1, 8'h00, 0, 1, 24'h000100, 0, 0);
      set_st(1'b0, 1'b1);
      do_read(8'h9F, 1, 1, 8'h00, 0, 1, 24'h000200, 0, 0);
      do_read(OP_READ, 1, 1, 8'h00, 0, 1, 24'h00FFFD, 1, 0);
      $display("test refusal done");
      end_of_test();
   end
endmodule : sfr_read_engine_test
